// *** core/ids_pkg.sv ***
// Package for the invert / count-down-skip execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`default_nettype none
package ids_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [1:0] CLASS_BYTE = 2'h0;
  localparam logic [3:0] OPC_INVERT = 4'h9;
  localparam logic [3:0] OPC_COUNT_DOWN = 4'hb;
  localparam int CLASS_HI = 13;
  localparam int CLASS_LO = 12;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 8;
  localparam int TGT_BIT = 7;
  localparam int ADDR_HI = 6;
  localparam int ADDR_LO = 0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

  typedef enum {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} ids_phase_e;

  // Write request toward accumulator or register file
  typedef struct packed {
    logic acc_we;
    logic reg_we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ids_wr_s;
endpackage
`default_nettype wire

// *** core/ids_exec.sv ***
// Execution logic for the invert and count-down-skip instructions.
// Assumes the register file answers a read address combinationally and
// the core advances phases in lock step with this block's phase_four.
`timescale 1ns/1ps
`default_nettype none
module ids_exec
  import ids_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ids_pkg::INSTR_W-1:0] instr,
  input wire logic [ids_pkg::DATA_W-1:0] rd_data,
  output logic [ids_pkg::ADDR_W-1:0] rd_addr,
  output ids_pkg::ids_wr_s wr,
  output logic zero_we,
  output logic zero_val,
  output logic skip_active,
  output logic [1:0] phase,
  output logic instr_done
);
  import ids_pkg::*;

  ids_phase_e ph_r, ph_nxt;
  logic skip_r, skip_nxt;
  logic [INSTR_W-1:0] ir_r;
  logic [DATA_W-1:0] opnd_r, res_r;
  ids_wr_s wr_r;
  logic zero_we_r, zero_val_r;

  function automatic logic is_op(input logic [INSTR_W-1:0] w, input logic [3:0] opc);
    return w[CLASS_HI:CLASS_LO] == CLASS_BYTE && w[OPC_HI:OPC_LO] == opc;
  endfunction

  wire logic dec_inv = is_op(ir_r, OPC_INVERT) && !skip_r;
  wire logic dec_cnt = is_op(ir_r, OPC_COUNT_DOWN) && !skip_r;
  wire logic tgt = ir_r[TGT_BIT];
  wire logic [ADDR_W-1:0] addr = ir_r[ADDR_HI:ADDR_LO];
  wire logic [DATA_W-1:0] res_calc = dec_inv ? ~opnd_r : DATA_W'(opnd_r - 8'h01);
  wire logic at_end = ph_r == PH_FOUR;

  always_comb begin
    case (ph_r)
      PH_ONE: ph_nxt = PH_TWO;
      PH_TWO: ph_nxt = PH_THREE;
      PH_THREE: ph_nxt = PH_FOUR;
      PH_FOUR: ph_nxt = PH_ONE;
      default: ph_nxt = PH_ONE;
    endcase
  end

  // A zero count-down result turns the next whole cycle into a no-op
  assign skip_nxt = at_end ? (dec_cnt && res_r == DATA_RST) : skip_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_r <= PH_ONE;
      skip_r <= 1'b0;
      ir_r <= '0;
      opnd_r <= DATA_RST;
      res_r <= DATA_RST;
      wr_r <= '0;
      zero_we_r <= 1'b0;
      zero_val_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      skip_r <= skip_nxt;
      wr_r <= '0;
      zero_we_r <= 1'b0;
      case (ph_r)
        PH_ONE: ir_r <= instr;
        PH_TWO: opnd_r <= rd_data;
        PH_THREE: res_r <= res_calc;
        PH_FOUR: begin
          if (dec_inv || dec_cnt) begin
            wr_r.acc_we <= !tgt;
            wr_r.reg_we <= tgt;
            wr_r.addr <= addr;
            wr_r.data <= res_r;
          end
          // Only the invert op touches the zero flag
          zero_we_r <= dec_inv;
          zero_val_r <= res_r == DATA_RST;
        end
        default: ;
      endcase
    end
  end

  assign rd_addr = addr;
  assign wr = wr_r;
  assign zero_we = zero_we_r;
  assign zero_val = zero_val_r;
  assign skip_active = skip_r;
  assign phase = 2'(ph_r);
  assign instr_done = at_end;

  property p_inv_zero;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_inv) |=> zero_we && zero_val == ($past(opnd_r) == 8'hff);
  endproperty
  a_inv_zero: assert property (p_inv_zero) else $error("invert zero flag wrong");

  property p_inv_tgt;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_inv) |=> wr.acc_we == !$past(tgt) && wr.reg_we == $past(tgt);
  endproperty
  a_inv_tgt: assert property (p_inv_tgt) else $error("invert target wrong");

  property p_inv_val;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_TWO && is_op(ir_r, OPC_INVERT) && !skip_r) |=> ##2 wr.data == ~$past(rd_data, 3);
  endproperty
  a_inv_val: assert property (p_inv_val) else $error("invert value wrong");

  property p_cnt_noflag;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_cnt) |=> !zero_we;
  endproperty
  a_cnt_noflag: assert property (p_cnt_noflag) else $error("count-down touched flag");

  property p_cnt_tgt;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_cnt) |=> (wr.acc_we ^ wr.reg_we) && wr.reg_we == $past(tgt);
  endproperty
  a_cnt_tgt: assert property (p_cnt_tgt) else $error("count-down target wrong");

  property p_skip;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_cnt) |=> skip_r == ($past(opnd_r) == 8'h01);
  endproperty
  a_skip: assert property (p_skip) else $error("skip decision wrong");

  property p_cnt_val;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_TWO && is_op(ir_r, OPC_COUNT_DOWN) && !skip_r) |=> ##2 wr.data == DATA_W'($past(rd_data, 3) - 8'h01);
  endproperty
  a_cnt_val: assert property (p_cnt_val) else $error("count-down value wrong");

  // The count-down's own write lands in the first skip clock, so the quiet window starts one later
  property p_skip_idle;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_ONE && skip_r) |=> (!wr.acc_we && !wr.reg_we && !zero_we) [*4] ##1 !skip_r;
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("skip cycle not idle");

  // Checks on the outputs the rest of the core consumes
  // Phase must step once per clock; fetch is paced by it
  property p_phase_step;
    @(posedge sys_clk) disable iff (srst)
    !$past(srst) |-> phase == 2'($past(phase) + 2'h1);
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not advance");

  property p_done_next;
    @(posedge sys_clk) disable iff (srst)
    instr_done |=> phase == 2'h0;
  endproperty
  a_done_next: assert property (p_done_next) else $error("cycle did not wrap after last phase");

  // Address holds from the read phase to the write so one target is seen
  property p_rd_addr_hold;
    @(posedge sys_clk) disable iff (srst)
    (ph_r != PH_ONE) |=> $stable(rd_addr);
  endproperty
  a_rd_addr_hold: assert property (p_rd_addr_hold) else $error("read address moved mid cycle");

  property p_wr_onehot;
    @(posedge sys_clk) disable iff (srst)
    !(wr.acc_we && wr.reg_we);
  endproperty
  a_wr_onehot: assert property (p_wr_onehot) else $error("both targets written at once");

  // Write address is the operand's, never the next instruction's
  property p_wr_addr;
    @(posedge sys_clk) disable iff (srst)
    (wr.acc_we || wr.reg_we) |-> wr.addr == $past(rd_addr);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address wrong");

  // Enables are strobes; a held enable would write twice
  property p_wr_pulse;
    @(posedge sys_clk) disable iff (srst)
    (wr.acc_we || wr.reg_we || zero_we) |=> !wr.acc_we && !wr.reg_we && !zero_we;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe held too long");

  // Other instruction classes belong to other decoders
  property p_class_quiet;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && ir_r[CLASS_HI:CLASS_LO] != CLASS_BYTE) |=> !wr.acc_we && !wr.reg_we && !zero_we;
  endproperty
  a_class_quiet: assert property (p_class_quiet) else $error("foreign class wrote");

  // A skip may only come from a finished count-down
  property p_skip_src;
    @(posedge sys_clk) disable iff (srst)
    $rose(skip_r) |-> $past(dec_cnt) && phase == 2'h0;
  endproperty
  a_skip_src: assert property (p_skip_src) else $error("skip raised without count-down");

  property p_inv_noskip;
    @(posedge sys_clk) disable iff (srst)
    (ph_r == PH_FOUR && dec_inv) |=> !skip_r;
  endproperty
  a_inv_noskip: assert property (p_inv_noskip) else $error("invert caused a skip");

  // Skip covers a whole instruction cycle and never clears early
  property p_skip_hold;
    @(posedge sys_clk) disable iff (srst)
    (skip_r && ph_r != PH_FOUR) |=> skip_r;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("skip ended early");
endmodule // ids_exec
`default_nettype wire

// *** test/ids_exec_tb.sv ***
// Self-checking bench for the invert / count-down-skip execution block.
// Assumes one instruction every four clocks, driven 1 ns after the edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module ids_exec_tb;
  import ids_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [INSTR_W-1:0] instr = '0;
  logic [DATA_W-1:0] rd_data = '0;
  logic [ADDR_W-1:0] rd_addr;
  ids_wr_s wr;
  logic zero_we, zero_val, skip_active, instr_done;
  logic [1:0] phase;
  int err_total = 0;
  int cmp_count = 0;
  ids_exec ids_exec_inst (.sys_clk(sys_clk), .srst(srst), .instr(instr), .rd_data(rd_data), .rd_addr(rd_addr),
    .wr(wr), .zero_we(zero_we), .zero_val(zero_val), .skip_active(skip_active), .phase(phase),
    .instr_done(instr_done));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [13:0] mk(logic [1:0] c, logic [3:0] op, logic t, logic [6:0] a);
    return {c, op, t, a};
  endfunction
  // One instruction cycle; write, flag and skip outputs judged in the phase_one after it
  task automatic run(logic [13:0] ins, logic [7:0] rd, logic [1:0] we, logic [7:0] dat, logic zw, logic zv,
    logic sk);
    instr = ins;
    rd_data = rd;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("rd_addr", ins[6:0], rd_addr)
    @(posedge sys_clk);
    #1;
    `CHK("instr_done", 1'b1, instr_done)
    @(posedge sys_clk);
    #1;
    `CHK("we", we, {wr.acc_we, wr.reg_we})
    if (we != 2'b00) `CHK("data", dat, wr.data)
    if (we[0]) `CHK("wr_addr", ins[6:0], wr.addr)
    `CHK("zero_we", zw, zero_we)
    if (zw) `CHK("zero_val", zv, zero_val)
    `CHK("skip", sk, skip_active)
  endtask
  task automatic t_invert;
    run(mk(CLASS_BYTE, OPC_INVERT, 1'b0, 7'h15), 8'h13, 2'b10, 8'hec, 1'b1, 1'b0, 1'b0);
    run(mk(CLASS_BYTE, OPC_INVERT, 1'b1, 7'h7f), 8'hff, 2'b01, 8'h00, 1'b1, 1'b1, 1'b0);
    $display("test invert done");
  endtask
  task automatic t_count;
    run(mk(CLASS_BYTE, OPC_COUNT_DOWN, 1'b0, 7'h00), 8'h05, 2'b10, 8'h04, 1'b0, 1'b0, 1'b0);
    run(mk(CLASS_BYTE, OPC_COUNT_DOWN, 1'b1, 7'h22), 8'h00, 2'b01, 8'hff, 1'b0, 1'b0, 1'b0);
    run(mk(CLASS_BYTE, OPC_COUNT_DOWN, 1'b1, 7'h31), 8'h01, 2'b01, 8'h00, 1'b0, 1'b0, 1'b1);
    // Skip cycle: an invert offered here must leave no trace
    run(mk(CLASS_BYTE, OPC_INVERT, 1'b1, 7'h31), 8'h55, 2'b00, 8'h00, 1'b0, 1'b0, 1'b0);
    run(mk(CLASS_BYTE, OPC_INVERT, 1'b0, 7'h31), 8'h55, 2'b10, 8'haa, 1'b1, 1'b0, 1'b0);
    $display("test count down done");
  endtask
  task automatic t_other;
    run(mk(CLASS_BYTE, 4'ha, 1'b1, 7'h01), 8'h01, 2'b00, 8'h00, 1'b0, 1'b0, 1'b0);
    run(mk(2'h1, OPC_INVERT, 1'b1, 7'h02), 8'h01, 2'b00, 8'h00, 1'b0, 1'b0, 1'b0);
    $display("test other opcodes done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    // About 9 instruction cycles are needed; 2000 clocks is ample
    repeat (2000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    `CHK("phase", 2'h0, phase)
    t_invert();
    t_count();
    t_other();
    test_done();
  end
endmodule // ids_exec_tb
`default_nettype wire
